/* pkg/fset_pkg.sv */
// Purpose: shared constants and types for the flash suspend/error tracker
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes:   command codes are the one-byte opcodes seen on the serial link

package fset_pkg;

  // ---------------------------------------------------------------------
  // register map (byte addresses, low address byte decoded)
  // ---------------------------------------------------------------------
  localparam logic [7:0] ADDR_ERR_STAT  = 8'h00;
  localparam logic [7:0] ADDR_SUS_STAT  = 8'h04;
  localparam logic [7:0] ADDR_CTRL      = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h10;
  localparam logic [7:0] ADDR_STATE     = 8'h14;

  // field positions
  localparam int BIT_ERA_ERR = 4;
  localparam int BIT_PRG_ERR = 5;
  localparam int BIT_PRG_SUS = 2;
  localparam int BIT_ERA_SUS = 3;
  localparam int BIT_SUS_ANY = 7;
  localparam int BIT_PDM     = 0;
  localparam int BIT_BUSY    = 0;
  localparam int BIT_OP_ERA  = 1;
  localparam int BIT_OP_PRG  = 2;
  localparam int BIT_DEEP    = 3;
  localparam int BIT_ULTRA   = 4;
  localparam int IRQ_W       = 4;
  localparam int IRQ_ERA_ERR = 0;
  localparam int IRQ_PRG_ERR = 1;
  localparam int IRQ_REFUSED = 2;
  localparam int IRQ_DONE    = 3;

  // reset values and opcode bit count
  localparam logic             RST_PDM  = 1'b1;
  localparam logic [IRQ_W-1:0] RST_MASK = 4'h0;
  localparam logic [3:0]       CMD_BITS = 4'h8;

  // ---------------------------------------------------------------------
  // command codes
  // ---------------------------------------------------------------------
  localparam logic [7:0] CMD_ERASE_4K   = 8'h20;
  localparam logic [7:0] CMD_ERASE_32K  = 8'h52;
  localparam logic [7:0] CMD_ERASE_64K  = 8'hd8;
  localparam logic [7:0] CMD_CHIP_ER_A  = 8'h60;
  localparam logic [7:0] CMD_CHIP_ER_B  = 8'hc7;
  localparam logic [7:0] CMD_PAGE_PRG   = 8'h02;
  localparam logic [7:0] CMD_PAGE_PRG_D = 8'ha2;
  localparam logic [7:0] CMD_PAGE_PRG_Q = 8'h32;
  localparam logic [7:0] CMD_SEQ_PRG_A  = 8'had;
  localparam logic [7:0] CMD_SEQ_PRG_B  = 8'haf;
  localparam logic [7:0] CMD_OTP_PRG    = 8'h9b;
  localparam logic [7:0] CMD_WR_SR1     = 8'h01;
  localparam logic [7:0] CMD_WR_SR2     = 8'h31;
  localparam logic [7:0] CMD_WR_SR3     = 8'h11;
  localparam logic [7:0] CMD_WR_SR_IND  = 8'h71;
  localparam logic [7:0] CMD_SR_LOCK    = 8'h6f;
  localparam logic [7:0] CMD_SUSPEND_A  = 8'h75;
  localparam logic [7:0] CMD_SUSPEND_B  = 8'hb0;
  localparam logic [7:0] CMD_RESUME_A   = 8'h7a;
  localparam logic [7:0] CMD_RESUME_B   = 8'hd0;
  localparam logic [7:0] CMD_TERMINATE  = 8'hf0;
  localparam logic [7:0] CMD_RST_EN     = 8'h66;
  localparam logic [7:0] CMD_RST        = 8'h99;
  localparam logic [7:0] CMD_PWR_DOWN   = 8'hb9;
  localparam logic [7:0] CMD_ULTRA_DOWN = 8'h79;
  localparam logic [7:0] CMD_WAKE       = 8'hab;

  // ---------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {OP_NONE, OP_ERASE, OP_PROGRAM} fset_op_type;
  typedef enum logic [1:0] {SLP_AWAKE, SLP_DEEP, SLP_ULTRA} fset_sleep_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] code;
  } fset_cmd_type;

  typedef struct packed {
    logic prg;
    logic era;
  } fset_err_type;

endpackage : fset_pkg

/* verilog/fset_tracker.sv */
// Purpose: suspend nesting and program/erase error flag tracking
// Assumes: serial link pins are asynchronous to sys_clk and sampled here;
//          op_done/op_fail come from the array sequencer on sys_clk
// Notes:   zero wait state AHB-Lite slave, one level interrupt

`timescale 1ns/1ps

module fset_tracker import fset_pkg::*; (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        spi_sck,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_si,
  input  wire logic        op_done,
  input  wire logic        op_fail,
  output logic             busy,
  output logic             erase_error_flag,
  output logic             program_error_flag,
  output logic             erase_suspend_flag,
  output logic             program_suspend_flag,
  output logic             suspend_summary_flag,
  output logic             deep_sleep_state,
  output logic             ultra_deep_sleep_state,
  output logic             irq
);

  // ---------------------------------------------------------------------
  // command classes
  // ---------------------------------------------------------------------
  function automatic logic is_erase(input logic [7:0] c);
    return (c == CMD_ERASE_4K) || (c == CMD_ERASE_32K) ||
           (c == CMD_ERASE_64K) || (c == CMD_CHIP_ER_A) ||
           (c == CMD_CHIP_ER_B);
  endfunction : is_erase

  function automatic logic is_program(input logic [7:0] c);
    return (c == CMD_PAGE_PRG) || (c == CMD_PAGE_PRG_D) ||
           (c == CMD_PAGE_PRG_Q) || (c == CMD_SEQ_PRG_A) ||
           (c == CMD_SEQ_PRG_B) || (c == CMD_OTP_PRG) ||
           (c == CMD_WR_SR1) || (c == CMD_WR_SR2) ||
           (c == CMD_WR_SR3) || (c == CMD_WR_SR_IND) ||
           (c == CMD_SR_LOCK);
  endfunction : is_program

  // ---------------------------------------------------------------------
  // serial link capture
  // ---------------------------------------------------------------------
  logic [2:0]   meta_q;
  logic [2:0]   sync_q;
  logic         sck_prev_q;
  logic         sck_prev_d;
  logic [3:0]   bit_cnt_q;
  logic [3:0]   bit_cnt_d;
  logic [7:0]   shift_q;
  logic [7:0]   shift_d;
  fset_cmd_type cmd_q;
  fset_cmd_type cmd_d;
  logic         sck_s;
  logic         cs_n_s;
  logic         si_s;

  assign sck_s  = sync_q[2];
  assign cs_n_s = sync_q[1];
  assign si_s   = sync_q[0];

  // only the opcode byte of a frame matters; the rest is ignored, bit_cnt_q holding at 8
  always_comb begin
    sck_prev_d = sck_s;
    bit_cnt_d  = bit_cnt_q;
    shift_d    = shift_q;
    cmd_d      = '0;
    if (cs_n_s) begin
      bit_cnt_d = '0;
    end else if (sck_s && !sck_prev_q && (bit_cnt_q != CMD_BITS)) begin
      shift_d   = {shift_q[6:0], si_s};
      bit_cnt_d = bit_cnt_q + 4'h1;
      if (bit_cnt_q == (CMD_BITS - 4'h1)) begin
        cmd_d.valid = 1'b1;
        cmd_d.code  = {shift_q[6:0], si_s};
      end
    end
  end

  // two flops per pin before anything looks at it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      // sck parks low and cs_n high, so no false edge follows reset
      meta_q     <= 3'h3;
      sync_q     <= 3'h3;
      sck_prev_q <= 1'b0;
      bit_cnt_q  <= '0;
      shift_q    <= '0;
      cmd_q      <= '0;
    end else begin
      meta_q     <= {spi_sck, spi_cs_n, spi_si};
      sync_q     <= meta_q;
      sck_prev_q <= sck_prev_d;
      bit_cnt_q  <= bit_cnt_d;
      shift_q    <= shift_d;
      cmd_q      <= cmd_d;
    end
  end

  // ---------------------------------------------------------------------
  // operation, suspend and error state
  // ---------------------------------------------------------------------
  fset_op_type    op_q;
  fset_op_type    op_d;
  fset_sleep_type slp_q;
  fset_sleep_type slp_d;
  fset_err_type   err_q;
  fset_err_type   err_d;
  logic           esus_q;
  logic           esus_d;
  logic           psus_q;
  logic           psus_d;
  logic           rst_en_q;
  logic           rst_en_d;
  logic           pdm_q;
  logic           ev_refused;
  logic           ev_done;
  fset_op_type    run_op;
  logic           int_reset;
  logic [7:0]     code;

  assign code = cmd_q.code;

  always_comb begin
    op_d       = op_q;
    slp_d      = slp_q;
    err_d      = err_q;
    esus_d     = esus_q;
    psus_d     = psus_q;
    rst_en_d   = rst_en_q;
    ev_refused = 1'b0;
    ev_done    = 1'b0;
    int_reset  = 1'b0;
    // completion first, so a suspend landing on the last cycle is moot
    if (op_done && (op_q != OP_NONE)) begin
      ev_done = 1'b1;
      op_d    = OP_NONE;
      if (op_q == OP_ERASE) begin
        esus_d = 1'b0;
      end else begin
        psus_d = 1'b0;
      end
    end
    run_op = op_d;
    if (cmd_q.valid) begin
      rst_en_d = (code == CMD_RST_EN);
      unique case (slp_q)
        SLP_AWAKE: begin
          if (is_erase(code)) begin
            if ((run_op == OP_NONE) && !psus_q &&
                !esus_q) begin
              err_d.era = 1'b0;
              op_d     = OP_ERASE;
            end else begin
              ev_refused = 1'b1;
            end
          end else if (is_program(code)) begin
            if ((run_op == OP_NONE) && !psus_q) begin
              err_d.prg = 1'b0;
              op_d     = OP_PROGRAM;
            end else begin
              ev_refused = 1'b1;
            end
          end else if ((code == CMD_SUSPEND_A) ||
                       (code == CMD_SUSPEND_B)) begin
            // error flags are not touched here
            if (run_op == OP_ERASE) begin
              esus_d = 1'b1;
              op_d = OP_NONE;
            end else if (run_op == OP_PROGRAM) begin
              psus_d = 1'b1;
              op_d = OP_NONE;
            end
          end else if ((code == CMD_RESUME_A) ||
                       (code == CMD_RESUME_B)) begin
            // program before erase; flags stay as they are
            if (run_op == OP_NONE) begin
              if (psus_q) begin
                op_d = OP_PROGRAM;
              end else if (esus_q) begin
                op_d = OP_ERASE;
              end
            end
          end else if (code == CMD_TERMINATE) begin
            // a cut operation cannot be resumed, so its suspend mark goes
            if (run_op == OP_ERASE) begin
              err_d.era = 1'b1;
              esus_d    = 1'b0;
              op_d      = OP_NONE;
            end else if (run_op == OP_PROGRAM) begin
              err_d.prg = 1'b1;
              psus_d    = 1'b0;
              op_d     = OP_NONE;
            end
          end else if ((code == CMD_RST) && rst_en_q) begin
            int_reset = 1'b1;
          end else if ((code == CMD_PWR_DOWN) && (run_op == OP_NONE)) begin
            slp_d = pdm_q ? SLP_DEEP : SLP_ULTRA;
          end else if ((code == CMD_ULTRA_DOWN) && (run_op == OP_NONE)) begin
            slp_d = SLP_ULTRA;
          end
          // anything else falls through with flags unchanged
        end
        SLP_DEEP: begin
          if (code == CMD_WAKE) begin
            slp_d = SLP_AWAKE;
          end else if ((code == CMD_RST) && rst_en_q) begin
            int_reset = 1'b1;
          end
        end
        SLP_ULTRA: begin
          if (code == CMD_WAKE) begin
            int_reset = 1'b1;
          end
        end
        default: begin
          slp_d = SLP_AWAKE;
        end
      endcase
    end
    // error detection after opcode decode so a set wins over a start's clear; only int_reset is later
    if (op_fail && (op_q == OP_ERASE)) begin
      err_d.era = 1'b1;
    end
    if (op_fail && (op_q == OP_PROGRAM)) begin
      err_d.prg = 1'b1;
    end
    if (int_reset) begin
      op_d     = OP_NONE;
      slp_d    = SLP_AWAKE;
      err_d    = '0;
      esus_d   = 1'b0;
      psus_d   = 1'b0;
      rst_en_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      op_q     <= OP_NONE;
      slp_q    <= SLP_AWAKE;
      err_q    <= '0;
      esus_q   <= 1'b0;
      psus_q   <= 1'b0;
      rst_en_q <= 1'b0;
    end else begin
      op_q     <= op_d;
      slp_q    <= slp_d;
      err_q    <= err_d;
      esus_q   <= esus_d;
      psus_q   <= psus_d;
      rst_en_q <= rst_en_d;
    end
  end

  assign busy                   = (op_q != OP_NONE);
  assign erase_error_flag       = err_q.era;
  assign program_error_flag     = err_q.prg;
  assign erase_suspend_flag     = esus_q;
  assign program_suspend_flag   = psus_q;
  assign suspend_summary_flag   = esus_q | psus_q;
  assign deep_sleep_state       = (slp_q == SLP_DEEP);
  assign ultra_deep_sleep_state = (slp_q == SLP_ULTRA);

  // ---------------------------------------------------------------------
  // register bus slave and interrupt
  // ---------------------------------------------------------------------
  logic             pdm_d;
  logic [IRQ_W-1:0] mask_q;
  logic [IRQ_W-1:0] mask_d;
  logic [IRQ_W-1:0] irq_q;
  logic [IRQ_W-1:0] irq_d;
  logic [IRQ_W-1:0] irq_ev;
  logic [31:0]      rdata_q;
  logic [31:0]      rdata_d;
  logic             wr_pend_q;
  logic             wr_pend_d;
  logic [7:0]       wr_addr_q;
  logic [7:0]       wr_addr_d;
  logic             accept;

  assign accept = hsel && htrans[1] && hready;

  always_comb begin
    irq_ev              = '0;
    irq_ev[IRQ_ERA_ERR] = err_d.era && !err_q.era;
    irq_ev[IRQ_PRG_ERR] = err_d.prg && !err_q.prg;
    irq_ev[IRQ_REFUSED] = ev_refused;
    irq_ev[IRQ_DONE]    = ev_done;
  end

  // read data is latched in the address phase, so a read right after a
  // write to the same register sees the value before that write
  always_comb begin
    pdm_d     = pdm_q;
    mask_d    = mask_q;
    irq_d     = irq_q;
    rdata_d   = rdata_q;
    wr_pend_d = accept && hwrite;
    wr_addr_d = accept ? haddr[7:0] : wr_addr_q;
    if (wr_pend_q) begin
      if (wr_addr_q == ADDR_CTRL) begin
        pdm_d = hwdata[BIT_PDM];
      end else if (wr_addr_q == ADDR_IRQ_MASK) begin
        mask_d = hwdata[IRQ_W-1:0];
      end
    end
    if (accept && !hwrite) begin
      rdata_d = '0;
      unique case (haddr[7:0])
        ADDR_ERR_STAT: begin
          rdata_d[BIT_ERA_ERR] = err_q.era;
          rdata_d[BIT_PRG_ERR] = err_q.prg;
        end
        ADDR_SUS_STAT: begin
          rdata_d[BIT_ERA_SUS] = esus_q;
          rdata_d[BIT_PRG_SUS] = psus_q;
          rdata_d[BIT_SUS_ANY] = esus_q | psus_q;
        end
        ADDR_CTRL: begin
          rdata_d[BIT_PDM] = pdm_q;
        end
        ADDR_IRQ_STAT: begin
          rdata_d[IRQ_W-1:0] = irq_q;
          irq_d              = '0;
        end
        ADDR_IRQ_MASK: begin
          rdata_d[IRQ_W-1:0] = mask_q;
        end
        ADDR_STATE: begin
          rdata_d[BIT_BUSY]   = (op_q != OP_NONE);
          rdata_d[BIT_OP_ERA] = (op_q == OP_ERASE);
          rdata_d[BIT_OP_PRG] = (op_q == OP_PROGRAM);
          rdata_d[BIT_DEEP]   = (slp_q == SLP_DEEP);
          rdata_d[BIT_ULTRA]  = (slp_q == SLP_ULTRA);
        end
        default: begin
          rdata_d = '0;
        end
      endcase
    end
    // new events win over the read-clear
    irq_d = irq_d | irq_ev;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pdm_q     <= RST_PDM;
      mask_q    <= RST_MASK;
      irq_q     <= '0;
      rdata_q   <= '0;
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
    end else begin
      pdm_q     <= pdm_d;
      mask_q    <= mask_d;
      irq_q     <= irq_d;
      rdata_q   <= rdata_d;
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
    end
  end

  assign hreadyout = 1'b1; // never stalls
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;
  assign irq       = |(irq_q & mask_q);

endmodule : fset_tracker

/* verif/fset_host_model.sv */
// Purpose: serial host model that issues one-byte flash opcodes
// Assumes: mode 0, serial clock low and still between frames
// Notes:   data line shows the inverse of its last bit when deselected
`timescale 1ns/1ps

module fset_host_model (
  output logic spi_sck,
  output logic spi_cs_n,
  output logic spi_si
);
  // ----------------------------------------------------------------
  // frame driver
  // ----------------------------------------------------------------
  // idle: deselected, clock parked low
  initial begin
    spi_sck  = 1'b0;
    spi_cs_n = 1'b1;
    spi_si   = 1'b1;
  end

  // one opcode per frame, msb first, 320 ns bit period
  task automatic send(input logic [7:0] code);
    spi_cs_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      spi_si = code[i];
      #160 spi_sck = 1'b1;
      #160 spi_sck = 1'b0;
    end
    #160 spi_cs_n = 1'b1;
    // a released line must not keep looking like valid data
    spi_si = ~spi_si;
  endtask : send
endmodule : fset_host_model

/* verif/fset_tracker_properties.sv */
// Purpose: concurrent checks on the suspend and error flag outputs
// Assumes: one sys_clk domain, rst asynchronous and active high
// Notes:   sees top ports only; opcode decode is judged by the bench
`timescale 1ns/1ps

module fset_tracker_properties (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic busy,
  input wire logic erase_error_flag,
  input wire logic program_error_flag,
  input wire logic erase_suspend_flag,
  input wire logic program_suspend_flag,
  input wire logic suspend_summary_flag,
  input wire logic ultra_deep_sleep_state
);
  // short aliases keep each property on one line
  wire logic eerr = erase_error_flag;
  wire logic perr = program_error_flag;
  wire logic esus = erase_suspend_flag;
  wire logic psus = program_suspend_flag;
  wire logic ud   = ultra_deep_sleep_state;
  // suspended and not running: nothing may touch that flag
  wire logic eh   = esus & ~busy;
  wire logic ph   = psus & ~busy;

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sum_or_a: assert property (suspend_summary_flag == (esus | psus))
    else $error("summary flag is not the or of the suspend flags");
  nest_order_a: assert property ($rose(esus) |-> !$past(psus))
    else $error("erase suspended inside a suspended program");
  erase_cause_a: assert property ($rose(eerr) |-> $past(busy))
    else $error("erase error flag set while idle");
  prog_cause_a: assert property ($rose(perr) |-> $past(busy))
    else $error("program error flag set while idle");
  erase_hold_a: assert property (eh && $past(eh) |-> $stable(eerr))
    else $error("erase error flag moved during erase suspend");
  prog_hold_a: assert property (ph && $past(ph) |-> $stable(perr))
    else $error("program error flag moved during program suspend");
  erase_resume_a: assert property (
      esus && $rose(busy) |-> $stable(eerr))
    else $error("erase error flag changed on resume");
  prog_resume_a: assert property (
      psus && $rose(busy) |-> $stable(perr))
    else $error("program error flag changed on resume");
  esus_rise_a: assert property (
      $rose(esus) |-> !busy && $past(busy))
    else $error("erase suspend flag rose without a running op");
  psus_rise_a: assert property (
      $rose(psus) |-> !busy && $past(busy))
    else $error("program suspend flag rose without a running op");
  rst_clear_a: assert property ($fell(rst) |-> !eerr && !perr)
    else $error("error flags not clear after reset");
  ultra_wake_a: assert property ($fell(ud) |-> !eerr && !perr)
    else $error("error flags survived ultra deep sleep exit");
endmodule : fset_tracker_properties

bind fset_tracker fset_tracker_properties chk_i (
  .sys_clk, .rst, .busy, .erase_error_flag, .program_error_flag,
  .erase_suspend_flag, .program_suspend_flag, .suspend_summary_flag,
  .ultra_deep_sleep_state
);

/* verif/fset_tracker_bench.sv */
// Purpose: self-checking bench for the suspend and error flag tracker
// Assumes: zero wait bus slave, flags settle within 8 cycles of a frame
// Notes:   fl packs irq and all flag outputs for one-call comparisons
`timescale 1ns/1ps

module fset_tracker_bench import fset_pkg::*;;
  logic             sys_clk      = 1'b0;
  logic             rst          = 1'b1;
  logic             hsel         = 1'b0;
  logic             hwrite       = 1'b0;
  logic             op_done      = 1'b0;
  logic             op_fail      = 1'b0;
  logic [1:0]       htrans       = 2'h0;
  logic [2:0]       hsize        = 3'h2;
  logic [31:0]      haddr        = 32'h0;
  logic [31:0]      hwdata       = 32'h0;
  logic [31:0]      rd;
  int               num_errors   = 0;
  int               total_checks = 0;
  int               cyc          = 0;
  wire logic        hreadyout, hresp, sck, cs_n, si, busy, e_err, p_err;
  wire logic        e_sus, p_sus, sm, dp, ud, irq;
  wire logic [31:0] hrdata;
  // hresp rides along so every flag compare also proves an OKAY response
  wire logic [31:0] fl = {22'h0, hresp, irq, ud, dp, sm, p_sus, e_sus,
                          p_err, e_err, busy};

  localparam logic [7:0] ERS [5] = '{CMD_ERASE_4K, CMD_ERASE_32K,
    CMD_ERASE_64K, CMD_CHIP_ER_A, CMD_CHIP_ER_B};
  localparam logic [7:0] PRG [11] = '{CMD_PAGE_PRG, CMD_PAGE_PRG_D,
    CMD_PAGE_PRG_Q, CMD_SEQ_PRG_A, CMD_SEQ_PRG_B, CMD_OTP_PRG,
    CMD_WR_SR1, CMD_WR_SR2, CMD_WR_SR3, CMD_WR_SR_IND, CMD_SR_LOCK};
  localparam logic [7:0] NEU [12] = '{CMD_SUSPEND_A, CMD_SUSPEND_B,
    CMD_RESUME_A, CMD_RESUME_B, CMD_TERMINATE, CMD_RST_EN, 8'h06,
    8'h03, 8'h9f, 8'h5a, 8'h77, 8'h7e};

  // ----------------------------------------------------------------
  // clock, design and host
  // ----------------------------------------------------------------
  always #20 sys_clk = ~sys_clk;

  fset_tracker dut (
    .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .spi_sck(sck), .spi_cs_n(cs_n), .spi_si(si),
    .op_done(op_done), .op_fail(op_fail), .busy(busy),
    .erase_error_flag(e_err), .program_error_flag(p_err),
    .erase_suspend_flag(e_sus), .program_suspend_flag(p_sus),
    .suspend_summary_flag(sm), .deep_sleep_state(dp),
    .ultra_deep_sleep_state(ud), .irq(irq)
  );

  fset_host_model host (.spi_sck(sck), .spi_cs_n(cs_n), .spi_si(si));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic end_sim;
    $display("checks %0d, errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  // single word transfer; each phase held until hready is seen high
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdchk

  // one frame, then the settle time of the opcode path
  task automatic step(input logic [7:0] c, input logic [31:0] e);
    host.send(c);
    repeat (8) @(posedge sys_clk);
    chk(fl, e);
  endtask : step

  // one-cycle pulse from the array sequencer: fail or done
  task automatic op(input logic f);
    @(posedge sys_clk);
    op_fail <= f;
    op_done <= ~f;
    @(posedge sys_clk);
    op_fail <= 1'b0;
    op_done <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask : op

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk(fl, 32'h0);
    rdchk(ADDR_CTRL, 32'h1);
    rdchk(ADDR_IRQ_MASK, 32'h0);
    rdchk(8'h3c, 32'h0);
    bus(1'b1, ADDR_ERR_STAT, 32'h30);
    rdchk(ADDR_ERR_STAT, 32'h0);
  endtask : t_reset

  // erase suspended before program, program resumed first
  task automatic t_nested;
    step(CMD_ERASE_4K, 32'h01);
    op(1'b1);
    chk(fl, 32'h03);
    step(CMD_SUSPEND_A, 32'h2a);
    step(CMD_PAGE_PRG, 32'h2b);
    op(1'b1);
    chk(fl, 32'h2f);
    step(CMD_SUSPEND_B, 32'h3e);
    rdchk(ADDR_SUS_STAT, 32'h8c);
    rdchk(ADDR_ERR_STAT, 32'h30);
    step(CMD_ERASE_64K, 32'h3e);
    bus(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk(rd & 32'h4, 32'h4);
    step(CMD_RESUME_B, 32'h3f);
    rdchk(ADDR_STATE, 32'h05);
    op(1'b0);
    chk(fl, 32'h2e);
    rdchk(ADDR_IRQ_STAT, 32'h8);
    step(CMD_RESUME_A, 32'h2f);
    op(1'b0);
    chk(fl, 32'h06);
  endtask : t_nested

  // every clearing opcode, each followed by a terminate
  task automatic t_codes;
    for (int i = 0; i < 5; i++) begin
      step(ERS[i], 32'h05);
      step(CMD_TERMINATE, 32'h06);
      rdchk(ADDR_ERR_STAT, 32'h30);
    end
    for (int i = 0; i < 11; i++) begin
      step(PRG[i], 32'h03);
      step(CMD_TERMINATE, 32'h06);
      rdchk(ADDR_ERR_STAT, 32'h30);
    end
    for (int i = 0; i < 12; i++) begin
      step(NEU[i], 32'h06);
    end
  endtask : t_codes

  task automatic t_sleep;
    step(CMD_PWR_DOWN, 32'h46);
    step(CMD_WAKE, 32'h06);
    bus(1'b1, ADDR_CTRL, 32'h0);
    step(CMD_PWR_DOWN, 32'h86);
    step(CMD_RST_EN, 32'h86);
    step(CMD_RST, 32'h86);
    step(CMD_WAKE, 32'h00);
    step(CMD_ERASE_4K, 32'h01);
    step(CMD_TERMINATE, 32'h02);
    step(CMD_RST_EN, 32'h02);
    step(CMD_RST, 32'h00);
    step(CMD_ULTRA_DOWN, 32'h80);
    step(CMD_WAKE, 32'h00);
    // software reset taken from deep sleep
    bus(1'b1, ADDR_CTRL, 32'h1);
    step(CMD_ERASE_4K, 32'h01);
    step(CMD_TERMINATE, 32'h02);
    step(CMD_PWR_DOWN, 32'h42);
    step(CMD_RST_EN, 32'h42);
    step(CMD_RST, 32'h00);
  endtask : t_sleep

  task automatic t_irq;
    bus(1'b1, ADDR_IRQ_MASK, 32'h1);
    rdchk(ADDR_IRQ_MASK, 32'h1);
    bus(1'b0, ADDR_IRQ_STAT, 32'h0);
    step(CMD_ERASE_4K, 32'h001);
    step(CMD_TERMINATE, 32'h102);
    bus(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk(rd & 32'h1, 32'h1);
    chk(fl, 32'h002);
    bus(1'b1, ADDR_IRQ_MASK, 32'h0);
    step(CMD_ERASE_4K, 32'h001);
    step(CMD_TERMINATE, 32'h002);
    // a second hardware reset in mid-run
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk(fl, 32'h0);
  endtask : t_irq

  // ----------------------------------------------------------------
  // sequence and hang guard
  // ----------------------------------------------------------------
  // a stalled bus or frame ends the run as a failure
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      end_sim;
    end
  end

  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    t_reset;
    t_nested;
    t_codes;
    t_sleep;
    t_irq;
    end_sim;
  end
endmodule : fset_tracker_bench
